// File: event_sync.sv
`timescale 1ns/1ps
module event_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // toggle from the other domain
    input  wire logic toggle_i,
    output logic      pulse_o
);
    logic meta;
    logic stable;
    logic last;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            last   <= 1'b0;
        end else begin
            meta   <= toggle_i;
            stable <= meta;
            last   <= stable;
        end
    end

    assign pulse_o = stable ^ last;
endmodule

// File: link_frame_tx.sv
`timescale 1ns/1ps
module link_frame_tx (
    // link clock and reset
    input  wire logic                 link_clk_i,
    input  wire logic                 link_reset_i,
    // frame hand-over
    input  wire logic                 start_i,
    input  wire pwm_user_pkg::frame_t frame_i,
    input  wire logic                 carrier_busy_i,
    // carrier side
    output logic                      bit_o,
    output logic                      frame_o,
    output logic                      done_toggle_o
);
    import pwm_user_pkg::*;

    typedef enum logic [1:0] {LK_IDLE, LK_GAP, LK_SHIFT} link_state_t;

    link_state_t           state;
    logic [FRAME_BITS-1:0] shreg;
    logic [6:0]            left;
    logic [7:0]            hi_cnt;

    always_ff @(posedge link_clk_i) begin
        if (link_reset_i) begin
            state         <= LK_IDLE;
            shreg         <= '0;
            left          <= 7'h00;
            bit_o         <= 1'b0;
            frame_o       <= 1'b0;
            done_toggle_o <= 1'b0;
        end else begin
            case (state)
                LK_IDLE: begin
                    if (start_i) begin
                        state <= LK_GAP;
                    end
                end
                LK_GAP: begin
                    if (!carrier_busy_i) begin
                        shreg <= frame_i;
                        left  <= FRAME_CNT;
                        state <= LK_SHIFT;
                    end
                end
                default: begin
                    if (left != 7'h00) begin
                        bit_o   <= shreg[FRAME_BITS-1];
                        frame_o <= 1'b1;
                        shreg   <= {shreg[FRAME_BITS-2:0], 1'b0};
                        left    <= left - 7'h01;
                    end else begin
                        bit_o         <= 1'b0;
                        frame_o       <= 1'b0;
                        done_toggle_o <= ~done_toggle_o;
                        state         <= LK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (link_reset_i) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= frame_o ? hi_cnt + 8'h01 : 8'h00;
        end
    end

    chk_frame_length: assert property (
        @(posedge link_clk_i) disable iff (link_reset_i)
        $fell(frame_o) |-> hi_cnt == {1'b0, FRAME_CNT})
        else $error("frame not 112 bits long");
endmodule

// File: pwm_remote_model.sv
`timescale 1ns/1ps
module pwm_remote_model
    import pwm_user_pkg::*;
(
    // carrier from the device
    input  wire logic link_clk_i,
    input  wire logic tx_bit_i,
    input  wire logic tx_frame_i,
    // carrier toward the device
    output logic      rx_bit_o,
    output logic      rx_frame_o
);
    frame_t       q[$];
    int           lens[$];
    logic [111:0] sh = '0;
    int           n = 0;
    initial begin
        rx_bit_o = 1'b0;
        rx_frame_o = 1'b0;
    end
    always @(posedge link_clk_i) begin
        if (tx_frame_i) begin
            sh <= {sh[110:0], tx_bit_i};
            n <= n + 1;
        end else if (n != 0) begin
            q.push_back(sh);
            lens.push_back(n);
            n <= 0;
        end
    end
    task automatic send(input frame_t f);
        for (int k = 111; k >= 0; k--) begin
            @(posedge link_clk_i);
            rx_frame_o <= 1'b1;
            rx_bit_o <= f[k];
        end
        @(posedge link_clk_i);
        rx_frame_o <= 1'b0;
        rx_bit_o <= ~f[0];
        repeat (4) @(posedge link_clk_i);
    endtask
endmodule

// File: pwm_user_data_channel.sv
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// How it works
// - bytes written through the tx port are framed and sent on the carrier.
// - accepted user frames push their data bytes into the receive fifo.
// - user frames wait for a carrier gap; other frame types are ignored.
// - a block holds at most 128 bytes.
// - sending never waits for any answer from the far end.
// - payload opens with status and size, then at most nine data bytes.
// - status byte holds a first-frame flag and seven-bit remaining count.
// - remaining count always stays below 128.
// - size byte counts valid data bytes, only one to nine.
// - payload bytes two to ten carry data; unused bytes are zero.
// - frame is 112 bits: 23-bit header, eleven bytes, parity bit.
// - header holds command, source id, broadcast flag, destination id.
// - a frame with broadcast set is taken whatever its destination.
module pwm_user_data_channel (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // avalon-mm slave
    input  wire logic [4:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // carrier link
    input  wire logic        link_clk_i,
    input  wire logic        carrier_busy_i,
    input  wire logic        rx_bit_i,
    input  wire logic        rx_frame_i,
    output logic             tx_bit_o,
    output logic             tx_frame_o
);
    import pwm_user_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} tx_state_t;

    logic [7:0]  tx_mem [BLOCK_MAX];
    logic [7:0]  rx_mem [BLOCK_MAX];
    logic [7:0]  src_id;
    logic [7:0]  dst_id;
    logic [7:0]  own_id;
    logic        bcast;
    tx_state_t   tx_state;
    logic [7:0]  tx_level;
    logic [7:0]  tx_left;
    logic [6:0]  tx_rd;
    logic        tx_first;
    logic        tx_req;
    frame_t      tx_frame_q;
    frame_t      next_frame;
    logic        tx_done;
    logic [7:0]  rx_level;
    logic [6:0]  rx_wr;
    logic [6:0]  rx_rd;
    logic [3:0]  rx_k;
    logic        rx_busy;
    logic        rx_ack;
    logic        rx_new;
    logic        overrun;
    logic [31:0] next_readdata;

    // ****************************************
    // bus decode
    // ****************************************
    wire       req_any = read_i | write_i;
    wire       wr_take = write_i & ~waitrequest_o;
    wire       rd_take = read_i & ~waitrequest_o;
    wire       sel_cfg = (address_i == ADDR_CFG);
    wire       sel_own = (address_i == ADDR_OWN_ID);
    wire       sel_txb = (address_i == ADDR_TX_BYTE);
    wire       sel_go  = (address_i == ADDR_TX_GO);
    wire       sel_st  = (address_i == ADDR_STATUS);
    wire       sel_rxd = (address_i == ADDR_RX_DATA);
    wire       tx_idle = (tx_state == TX_IDLE);
    wire       tx_push = wr_take & sel_txb & byteenable_i[0] & tx_idle
                         & (tx_level < BLOCK_MAX_W);
    wire       tx_go   = wr_take & sel_go & byteenable_i[0] & writedata_i[0]
                         & tx_idle & (tx_level != 8'h00);
    wire       rx_pop  = rd_take & sel_rxd & (rx_level != 8'h00);
    wire       rx_push = rx_busy & (rx_level != BLOCK_MAX_W);
    wire       ovr_clr = wr_take & sel_st & byteenable_i[2] & writedata_i[ST_OVERRUN];
    // at most nine data bytes a frame
    wire [3:0] tx_n    = (tx_left > MAX_DATA_W) ? MAX_DATA_N : tx_left[3:0];

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (sel_cfg) begin
            next_readdata = {15'h0000, bcast, dst_id, src_id};
        end else if (sel_own) begin
            next_readdata = {24'h00_0000, own_id};
        end else if (sel_st) begin
            next_readdata = {14'h0000, overrun, ~tx_idle, rx_level, tx_level};
        end else if (sel_rxd) begin
            next_readdata = {23'h00_0000, rx_level != 8'h00, rx_mem[rx_rd]};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
        end else begin
            waitrequest_o <= ~(req_any & waitrequest_o);
            if (req_any & waitrequest_o) begin
                readdata_o <= next_readdata;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            src_id  <= ID_RESET;
            dst_id  <= ID_RESET;
            own_id  <= ID_RESET;
            bcast   <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (wr_take & sel_cfg & byteenable_i[0]) begin
                src_id <= writedata_i[7:0];
            end
            if (wr_take & sel_cfg & byteenable_i[1]) begin
                dst_id <= writedata_i[CFG_DST_LSB +: 8];
            end
            if (wr_take & sel_cfg & byteenable_i[2]) begin
                bcast <= writedata_i[CFG_BCAST];
            end
            if (wr_take & sel_own & byteenable_i[0]) begin
                own_id <= writedata_i[7:0];
            end
            // set wins over software clear
            if (rx_busy & ~rx_push) begin
                overrun <= 1'b1;
            end else if (ovr_clr) begin
                overrun <= 1'b0;
            end
        end
    end

    // ****************************************
    // transmit block and frame build
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (tx_push) begin
            tx_mem[tx_level[6:0]] <= writedata_i[7:0];
        end
    end

    always_comb begin
        next_frame = '0;
        next_frame.cmd   = CMD_USER;
        next_frame.src   = src_id;
        next_frame.bcast = bcast;
        next_frame.dst   = dst_id;
        next_frame.payload.first     = tx_first;
        // bytes after this frame, below 128
        next_frame.payload.remaining = 7'(tx_left - {4'h0, tx_n});
        next_frame.payload.size      = {4'h0, tx_n};
        for (int k = 0; k < MAX_DATA; k++) begin
            if (k < int'(tx_n)) begin
                next_frame.payload.data[MAX_DATA-1-k] = tx_mem[7'(tx_rd + 7'(k))];
            end
        end
        next_frame.parity = parity_of(next_frame);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_state   <= TX_IDLE;
            tx_level   <= 8'h00;
            tx_left    <= 8'h00;
            tx_rd      <= 7'h00;
            tx_first   <= 1'b0;
            tx_req     <= 1'b0;
            tx_frame_q <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_go) begin
                        tx_left  <= tx_level;
                        tx_rd    <= 7'h00;
                        tx_first <= 1'b1;
                        tx_state <= TX_SEND;
                    end else if (tx_push) begin
                        tx_level <= tx_level + 8'h01;
                    end
                end
                TX_SEND: begin
                    tx_frame_q <= next_frame;
                    tx_req     <= ~tx_req;
                    tx_state   <= TX_WAIT;
                end
                default: begin
                    // done is local, no far-end answer
                    if (tx_done) begin
                        tx_rd    <= tx_rd + 7'(tx_n);
                        tx_left  <= tx_left - {4'h0, tx_n};
                        tx_first <= 1'b0;
                        if (tx_left == {4'h0, tx_n}) begin
                            tx_level <= 8'h00;
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_state <= TX_SEND;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************
    // link domain
    // ****************************************
    logic       lrst_meta;
    logic       link_rst;
    logic [2:0] pin_meta;
    logic [2:0] pin_s;
    logic [7:0] id_meta;
    logic [7:0] id_link;
    logic       tx_start;
    logic       tx_done_tgl;
    logic       rx_ack_l;
    frame_t     rx_sh;
    frame_t     rx_word;
    logic [6:0] rx_cnt;
    logic       rx_req;
    logic       rx_pend;

    always_ff @(posedge link_clk_i) begin
        lrst_meta <= reset_i;
        link_rst  <= lrst_meta;
        pin_meta  <= {rx_bit_i, rx_frame_i, carrier_busy_i};
        pin_s     <= pin_meta;
        id_meta   <= own_id;
        id_link   <= id_meta;
    end

    event_sync u_start_sync (
        .clk_i    (link_clk_i),
        .reset_i  (link_rst),
        .toggle_i (tx_req),
        .pulse_o  (tx_start)
    );

    link_frame_tx u_link_tx (
        .link_clk_i     (link_clk_i),
        .link_reset_i   (link_rst),
        .start_i        (tx_start),
        .frame_i        (tx_frame_q),
        .carrier_busy_i (pin_s[0]),
        .bit_o          (tx_bit_o),
        .frame_o        (tx_frame_o),
        .done_toggle_o  (tx_done_tgl)
    );

    event_sync u_done_sync (
        .clk_i    (ref_clk_i),
        .reset_i  (reset_i),
        .toggle_i (tx_done_tgl),
        .pulse_o  (tx_done)
    );

    wire rx_end  = ~pin_s[1] & (rx_cnt != 7'h00);
    wire rx_par  = ~(^rx_sh);
    wire rx_size = (rx_sh.payload.size != 8'h00) && (rx_sh.payload.size <= MAX_DATA_W);
    wire rx_addr = rx_sh.bcast | (rx_sh.dst == id_link);
    wire rx_good = (rx_cnt == FRAME_CNT) & rx_par & rx_size & rx_addr
                   & (rx_sh.cmd == CMD_USER);
    wire rx_take = rx_end & rx_good & ~rx_pend;

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            rx_sh   <= '0;
            rx_word <= '0;
            rx_cnt  <= 7'h00;
            rx_req  <= 1'b0;
            rx_pend <= 1'b0;
        end else begin
            if (pin_s[1]) begin
                rx_sh <= {rx_sh[FRAME_BITS-2:0], pin_s[2]};
                if (rx_cnt != CNT_SAT) begin
                    rx_cnt <= rx_cnt + 7'h01;
                end
            end else begin
                rx_cnt <= 7'h00;
            end
            // hold payload for the fifo side
            if (rx_take) begin
                rx_word <= rx_sh;
                rx_req  <= ~rx_req;
                rx_pend <= 1'b1;
            end else if (rx_ack_l) begin
                rx_pend <= 1'b0;
            end
        end
    end

    event_sync u_ack_sync (
        .clk_i    (link_clk_i),
        .reset_i  (link_rst),
        .toggle_i (rx_ack),
        .pulse_o  (rx_ack_l)
    );

    event_sync u_new_sync (
        .clk_i    (ref_clk_i),
        .reset_i  (reset_i),
        .toggle_i (rx_req),
        .pulse_o  (rx_new)
    );

    // ****************************************
    // receive fifo
    // ****************************************
    wire [7:0] rx_byte = rx_word.payload.data[LAST_IDX - rx_k];
    wire       rx_last = ({4'h0, rx_k} == rx_word.payload.size - 8'h01);

    always_ff @(posedge ref_clk_i) begin
        if (rx_push) begin
            rx_mem[rx_wr] <= rx_byte;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_busy  <= 1'b0;
            rx_k     <= 4'h0;
            rx_ack   <= 1'b0;
            rx_wr    <= 7'h00;
            rx_rd    <= 7'h00;
            rx_level <= 8'h00;
        end else begin
            if (rx_new) begin
                rx_busy <= 1'b1;
                rx_k    <= 4'h0;
            end else if (rx_busy) begin
                rx_k <= rx_k + 4'h1;
                if (rx_last) begin
                    rx_busy <= 1'b0;
                    rx_ack  <= ~rx_ack;
                end
            end
            if (rx_push) begin
                rx_wr <= rx_wr + 7'h01;
            end
            if (rx_pop) begin
                rx_rd <= rx_rd + 7'h01;
            end
            if (rx_push & ~rx_pop) begin
                rx_level <= rx_level + 8'h01;
            end else if (rx_pop & ~rx_push) begin
                rx_level <= rx_level - 8'h01;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_tx_launch: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        tx_state == TX_SEND |=> tx_state == TX_WAIT && $changed(tx_req))
        else $error("frame not launched");

    chk_rx_unload: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        rx_new |=> rx_busy ##1 $changed(rx_k))
        else $error("received frame not unloaded");

    chk_block_cap: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        tx_push |-> tx_level < BLOCK_MAX_W ##1 tx_level <= BLOCK_MAX_W)
        else $error("block over 128 bytes");

    chk_first_flag: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        tx_state == TX_SEND |=> tx_frame_q.payload.first == ($past(tx_rd) == 7'h00))
        else $error("first flag misplaced");

    chk_remaining_count: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        tx_state == TX_SEND |=> 8'(tx_frame_q.payload.remaining)
            == tx_left - tx_frame_q.payload.size)
        else $error("remaining count wrong");

    chk_size_legal: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $changed(tx_req) |-> tx_frame_q.payload.size inside {[8'h01:8'h09]})
        else $error("size out of range");

    chk_header_cmd: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        tx_state == TX_WAIT |-> tx_frame_q.cmd == CMD_USER
            && tx_frame_q.parity == parity_of(tx_frame_q))
        else $error("bad header or parity");

    chk_rx_filter: assert property (
        @(posedge link_clk_i) disable iff (link_rst)
        $changed(rx_req) |-> $past(rx_par) && $past(rx_size))
        else $error("bad frame accepted");

    chk_bcast_accept: assert property (
        @(posedge link_clk_i) disable iff (link_rst)
        rx_end && rx_sh.bcast && rx_par && rx_size && rx_cnt == FRAME_CNT
            && rx_sh.cmd == CMD_USER && !rx_pend |=> $changed(rx_req))
        else $error("broadcast frame not taken");
endmodule

// File: pwm_user_pkg.sv
package pwm_user_pkg;

    // ****************************************
    // frame geometry
    // ****************************************
    localparam int         FRAME_BITS  = 112;
    localparam int         MAX_DATA    = 9;
    localparam int         BLOCK_MAX   = 128;
    localparam logic [6:0] FRAME_CNT   = 7'h70;
    localparam logic [6:0] CNT_SAT     = 7'h7F;
    localparam logic [3:0] MAX_DATA_N  = 4'h9;
    localparam logic [7:0] MAX_DATA_W  = 8'h09;
    localparam logic [3:0] LAST_IDX    = 4'h8;
    localparam logic [7:0] BLOCK_MAX_W = 8'h80;
    localparam logic [2:0] CMD_USER    = 3'h5;

    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [4:0] ADDR_CFG     = 5'h00;
    localparam logic [4:0] ADDR_OWN_ID  = 5'h04;
    localparam logic [4:0] ADDR_TX_BYTE = 5'h08;
    localparam logic [4:0] ADDR_TX_GO   = 5'h0C;
    localparam logic [4:0] ADDR_STATUS  = 5'h10;
    localparam logic [4:0] ADDR_RX_DATA = 5'h14;
    localparam int         CFG_DST_LSB  = 8;
    localparam int         CFG_BCAST    = 16;
    localparam int         ST_RX_LSB    = 8;
    localparam int         ST_TX_BUSY   = 16;
    localparam int         ST_OVERRUN   = 17;
    localparam int         RX_VALID     = 8;
    localparam logic [7:0] ID_RESET     = 8'h00;

    typedef struct packed {
        logic            first;
        logic [6:0]      remaining;
        logic [7:0]      size;
        logic [8:0][7:0] data;
    } user_payload_t;

    typedef struct packed {
        logic [2:0]    cmd;
        logic [2:0]    rsvd;
        logic [7:0]    src;
        logic          bcast;
        logic [7:0]    dst;
        user_payload_t payload;
        logic          parity;
    } frame_t;

    // even parity over the whole frame
    function automatic logic parity_of(input frame_t f);
        return ^f[FRAME_BITS-1:1];
    endfunction

endpackage

// File: test_pwm_user_data_channel.sv
`timescale 1ns/1ps
module test_pwm_user_data_channel;
    import pwm_user_pkg::*;
    logic        ref_clk_i = 0, reset_i = 1, read_i = 0, write_i = 0;
    logic        link_clk_i = 0, carrier_busy_i = 0, tx_bit_o, tx_frame_o;
    logic [4:0]  address_i = '0;
    logic [31:0] writedata_i = '0, readdata_o, rd;
    logic [3:0]  byteenable_i = 4'hF;
    logic        waitrequest_o, rx_bit_i, rx_frame_i;
    int          errors = 0, checked = 0;
    frame_t      f;
    pwm_user_data_channel u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .link_clk_i(link_clk_i),
        .carrier_busy_i(carrier_busy_i), .rx_bit_i(rx_bit_i), .rx_frame_i(rx_frame_i),
        .tx_bit_o(tx_bit_o), .tx_frame_o(tx_frame_o));
    pwm_remote_model m (.link_clk_i(link_clk_i), .tx_bit_i(tx_bit_o),
        .tx_frame_i(tx_frame_o), .rx_bit_o(rx_bit_i), .rx_frame_o(rx_frame_i));
    initial forever #25 ref_clk_i = ~ref_clk_i;
    // carrier clock: 6 ns period, offset so its edges never meet the system clock's
    initial begin
        #1.3;
        forever #3 link_clk_i = ~link_clk_i;
    end
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= ~wr;
        do @(posedge ref_clk_i); while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask
    task automatic check(input logic [111:0] got, input logic [111:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic frame_t mk(logic fst, logic [6:0] rem, logic [7:0] sz,
                                  logic [7:0] b, logic [7:0] d, logic bc);
        frame_t r;
        r = '0;
        r.cmd = CMD_USER;
        r.src = 8'h3C;
        r.bcast = bc;
        r.dst = d;
        r.payload.first = fst;
        r.payload.remaining = rem;
        r.payload.size = sz;
        for (int i = 0; i < sz && i < 9; i++) r.payload.data[8-i] = b + i[7:0];
        r.parity = ^r[111:1];
        return r;
    endfunction
    // sends n bytes k=b+0.. and judges every frame of the block
    task automatic tx_block(input int n, input logic [7:0] b);
        int left, sz, t;
        m.q.delete();
        m.lens.delete();
        for (int k = 0; k < n; k++) bus(1, ADDR_TX_BYTE, 32'(b + k[7:0]));
        bus(0, ADDR_STATUS, 0);
        check(rd[7:0], n[7:0]);
        bus(1, ADDR_TX_GO, 32'h1);
        repeat (60) @(posedge ref_clk_i);
        check(m.q.size(), 0);
        carrier_busy_i <= 1'b0;
        left = n;
        t = 0;
        while (m.q.size() < (n + 8) / 9 && t < 4000) begin
            @(posedge ref_clk_i);
            t++;
        end
        if (t >= 4000) errors++;
        // let the last done toggle cross back before judging the idle state
        repeat (8) @(posedge ref_clk_i);
        bus(0, ADDR_STATUS, 0);
        check(rd[16:0], 17'h0_0000);
        for (int i = 0; i < (n + 8) / 9; i++) begin
            sz = (left > 9) ? 9 : left;
            left -= sz;
            check(m.q[i], mk(i == 0, left[6:0], sz[7:0], b + 8'(9 * i), 8'h5A, 0));
            check(m.lens[i], 112);
        end
        $display("tx block of %0d done", n);
    endtask
    task automatic rx_test();
        bus(1, ADDR_OWN_ID, 32'h21);
        m.send(mk(1, 0, 3, 8'hA0, 8'h21, 0));
        m.send(mk(1, 0, 1, 8'hB0, 8'h99, 1));
        f = mk(1, 0, 2, 8'hC0, 8'h21, 0);
        f.parity = ~f.parity;
        m.send(f);
        m.send(mk(1, 0, 0, 8'hC0, 8'h21, 0));
        m.send(mk(1, 0, 10, 8'hC0, 8'h21, 0));
        m.send(mk(1, 0, 1, 8'hC0, 8'h22, 0));
        f = mk(1, 0, 1, 8'hC0, 8'h21, 0);
        f.cmd = 3'h0;
        f.parity = ^f[111:1];
        m.send(f);
        repeat (10) @(posedge ref_clk_i);
        bus(0, ADDR_STATUS, 0);
        check(rd[15:8], 4);
        for (int i = 0; i < 3; i++) begin
            bus(0, ADDR_RX_DATA, 0);
            check(rd[8:0], {1'b1, 8'hA0 + i[7:0]});
        end
        bus(0, ADDR_RX_DATA, 0);
        check(rd[8:0], 9'h1B0);
        bus(0, ADDR_RX_DATA, 0);
        check(rd[8], 0);
        bus(0, 5'h18, 0);
        check(rd, 0);
        $display("rx test done");
    endtask
    // sends 135 bytes into a 128 byte fifo, then clears the sticky overrun flag
    task automatic rx_fill();
        for (int j = 0; j < 15; j++) m.send(mk(j == 0, 7'h00, 8'h09, 8'(9 * j), 8'h21, 0));
        repeat (20) @(posedge ref_clk_i);
        bus(0, ADDR_STATUS, 0);
        check(rd[17:8], 10'h280);
        bus(1, ADDR_STATUS, 32'h0002_0000);
        bus(0, ADDR_STATUS, 0);
        check(rd[17], 0);
        bus(0, ADDR_RX_DATA, 0);
        check(rd[8:0], 9'h100);
        $display("rx overrun test done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        bus(1, ADDR_CFG, 32'h00005A3C);
        carrier_busy_i <= 1'b1;
        tx_block(11, 8'h10);
        carrier_busy_i <= 1'b1;
        tx_block(128, 8'h00);
        rx_test();
        rx_fill();
        end_of_test();
    end
    initial begin
        #2ms;
        errors++;
        end_of_test();
    end
endmodule
